// ==== rtl/asc_pkg.sv ====
// Constants, register map and carrier types of the converter control block.
// Assumes one 250 MHz core clock; the converter oscillator equals that clock.
package asc_pkg;

	// Printed register offsets are indexes; the byte address is four times the index
	localparam logic [9:0] ASC_IDX_RESULT = 10'h01e;
	localparam logic [9:0] ASC_IDX_CTRL_MAIN = 10'h01f;
	localparam logic [9:0] ASC_IDX_REF_SEL = 10'h09f;
	localparam logic [9:0] ASC_IDX_PORT_A = 10'h005;
	localparam logic [9:0] ASC_IDX_PORT_B = 10'h006;
	localparam logic [9:0] ASC_IDX_IRQ = 10'h020;
	localparam logic [9:0] ASC_IDX_ANALOG_SEL = 10'h021;
	localparam int ASC_ADDR_W = 12;

	// Control register 0 fields
	localparam int ASC_POWER_BIT = 0;
	localparam int ASC_INT_SRC_BIT = 1;
	localparam int ASC_GO_BIT = 2;
	localparam int ASC_CHAN_LSB = 3;
	localparam int ASC_CLKSEL_LSB = 6;
	// Control register 1 field
	localparam int ASC_REFSEL_LSB = 4;
	// Interrupt register fields
	localparam int ASC_FLAG_BIT = 0;
	localparam int ASC_IRQEN_BIT = 1;

	localparam logic [7:0] ASC_CTRL_RESET = 8'h00;
	localparam logic [7:0] ASC_REF_MASK = 8'h30;

	// Conversion clock selections
	localparam logic [1:0] ASC_CLK_DIV2 = 2'h0;
	localparam logic [1:0] ASC_CLK_DIV8 = 2'h1;
	localparam logic [1:0] ASC_CLK_DIV32 = 2'h2;
	localparam logic [1:0] ASC_CLK_RC = 2'h3;

	// Oscillator divisions, then half a conversion clock period in core cycles
	localparam int ASC_DIV2 = 2;
	localparam int ASC_DIV8 = 8;
	localparam int ASC_DIV32 = 32;
	localparam logic [4:0] ASC_HALF_DIV2 = 5'(ASC_DIV2 / 2);
	localparam logic [4:0] ASC_HALF_DIV8 = 5'(ASC_DIV8 / 2);
	localparam logic [4:0] ASC_HALF_DIV32 = 5'(ASC_DIV32 / 2);

	// Conversion is 9.5 periods, the abort pause 2 periods, both in half periods
	localparam logic [4:0] ASC_CONV_HALVES = 5'h13;
	localparam logic [4:0] ASC_ABORT_HALVES = 5'h04;
	localparam logic [4:0] ASC_SAMPLE_HALVES = 5'h02;

	localparam logic [1:0] ASC_RESP_OKAY = 2'h0;
	localparam logic [1:0] ASC_RESP_SLVERR = 2'h2;

	// Signals toward the analog multiplexer and sample-hold converter
	typedef struct packed {
		logic powered;
		logic connect;
		logic internalSource;
		logic [2:0] channel;
		logic [1:0] reference;
		logic sampling;
		logic [7:0] trial;
	} asc_analog_t;

endpackage

// ==== rtl/asc_tad_clock.sv ====
// Conversion clock generator: one pulse every half conversion clock period.
// Assumes the dedicated RC oscillator arrives as a one-cycle pulse per half period.
`timescale 1ns/100ps
`default_nettype none
module asc_step_clock
	import asc_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic run,
	input wire logic [1:0] clockSelect,
	input wire logic rcHalfTick,
	input wire logic cpuSleep,
	output logic halfTick
);

	logic [4:0] count;
	logic [4:0] halfPeriod;
	logic stalled;

	always_comb
	begin
		case (clockSelect)
			ASC_CLK_DIV2: halfPeriod = ASC_HALF_DIV2;
			ASC_CLK_DIV8: halfPeriod = ASC_HALF_DIV8;
			ASC_CLK_DIV32: halfPeriod = ASC_HALF_DIV32;
			default: halfPeriod = ASC_HALF_DIV2;
		endcase
	end

	// The oscillator stops in sleep; only the RC source keeps running
	assign stalled = cpuSleep && (clockSelect != ASC_CLK_RC);

	always_ff @(posedge core_clk)
	begin
		if (sys_rst || !run)
		begin
			count <= 5'h00;
			halfTick <= 1'b0;
		end
		else if (clockSelect == ASC_CLK_RC)
		begin
			count <= 5'h00;
			halfTick <= rcHalfTick;
		end
		else if (stalled)
			halfTick <= 1'b0;
		else if (count == halfPeriod - 5'h01)
		begin
			count <= 5'h00;
			halfTick <= 1'b1;
		end
		else
		begin
			count <= count + 5'h01;
			halfTick <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ==== rtl/asc_sar.sv ====
// Successive approximation engine, stepped by half conversion clock pulses.
// Assumes the comparator answers within one half period of a new trial value.
`timescale 1ns/100ps
`default_nettype none
module asc_sar
	import asc_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic abort,
	input wire logic halfTick,
	input wire logic compareHigh,
	output logic busy,
	output logic sampling,
	output logic done,
	output logic [7:0] trial
);

	logic [4:0] halfCount;
	logic [7:0] bitMask;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst || abort)
		begin
			busy <= 1'b0;
			sampling <= 1'b0;
			done <= 1'b0;
			halfCount <= 5'h00;
			bitMask <= 8'h00;
			trial <= 8'h00;
		end
		else if (start && !busy)
		begin
			busy <= 1'b1;
			sampling <= 1'b1;
			done <= 1'b0;
			halfCount <= 5'h00;
			bitMask <= 8'h80;
			trial <= 8'h80;
		end
		else if (busy && halfTick)
		begin
			halfCount <= halfCount + 5'h01;
			if (halfCount == ASC_SAMPLE_HALVES - 5'h01)
				sampling <= 1'b0;
			// One bit decided on every odd half after the hold
			if (halfCount[0] && halfCount > ASC_SAMPLE_HALVES && bitMask != 8'h00)
			begin
				trial <= (compareHigh ? trial : (trial & ~bitMask)) | (bitMask >> 1);
				bitMask <= bitMask >> 1;
			end
			if (halfCount == ASC_CONV_HALVES - 5'h01)
			begin
				busy <= 1'b0;
				done <= 1'b1;
			end
		end
		else
			done <= 1'b0;
	end

endmodule
`default_nettype wire

// ==== rtl/asc_control.sv ====
// Converter control top: AXI4-Lite registers, sequencing and analog controls.
// Assumes a comparator result input and a synchronous RC oscillator pulse input.
//
// How it works
// - Power bit enables the converter; clearing it ends any running conversion.
// - Clock select picks oscillator /2, /8, /32 or the RC oscillator.
// - External codes pick inputs 0-7; internal 000 reference, 001 DAC.
// - Writing go starts conversion; hardware holds it, then clears it at the end.
// - Completion loads the 8-bit result; software can read and write it.
// - Completion sets the sticky complete flag until software clears it.
// - With enable set, completion also raises an interrupt request.
// - Result made by successive approximation on the held sample.
// - Reference field picks supply, comparator reference, reference output or DAC.
// - Unused bits of control register 1 read zero and ignore writes.
// - Conversion continues in sleep only with the RC oscillator selected.
// - Conversion ignores pin direction and analog select; firmware sets them.
// - Port reads return zero on pins set as analog inputs.
// - A conversion lasts nine and a half conversion clock periods.
// - Clearing go aborts and keeps the last completed result.
// - After an abort wait two periods, then acquire automatically.
`timescale 1ns/100ps
`default_nettype none
module asc_control
	import asc_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [ASC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ASC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cpuSleep,
	input wire logic rcHalfTick,
	input wire logic compareHigh,
	input wire logic [7:0] portAPins,
	input wire logic [7:0] portBPins,
	output asc_analog_t analog,
	output logic irqRequest
);

	typedef enum logic [1:0] {ASC_ACQUIRE, ASC_CONVERT, ASC_ABORT_WAIT} asc_state_t;

	////////////////////////////////////////////////////////////////////////////////
	// Register state

	logic powerOn;
	logic internalSource;
	logic goDone;
	logic [2:0] channelLow;
	logic [1:0] clockSelect;
	logic [1:0] referenceSelect;
	logic [7:0] conversionResult;
	logic completeFlag;
	logic irqEnable;
	logic [7:0] analogSelect;
	asc_state_t state;
	logic [4:0] abortHalves;
	logic awHeld;
	logic wHeld;
	logic [ASC_ADDR_W-1:0] awAddr;
	logic [7:0] wByte;
	logic wLane0;
	logic writeNow;
	logic [9:0] writeIdx;
	logic readNow;
	logic [9:0] readIdx;
	logic halfTick;
	logic sarBusy;
	logic sarSampling;
	logic sarDone;
	logic [7:0] sarTrial;
	logic sarAbort;
	logic sarStart;
	logic channelValid;

	function automatic logic [9:0] regIndex(input logic [ASC_ADDR_W-1:0] addr);
		regIndex = addr[11:2];
	endfunction

	function automatic logic isMapped(input logic [9:0] idx);
		isMapped = (idx == ASC_IDX_RESULT) || (idx == ASC_IDX_CTRL_MAIN) ||
			(idx == ASC_IDX_REF_SEL) || (idx == ASC_IDX_PORT_A) ||
			(idx == ASC_IDX_PORT_B) || (idx == ASC_IDX_IRQ) ||
			(idx == ASC_IDX_ANALOG_SEL);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel

	assign writeNow = awHeld && wHeld && !s_axi_bvalid;
	assign writeIdx = regIndex(awAddr);

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= '0;
			wByte <= 8'h00;
			wLane0 <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ASC_RESP_OKAY;
		end
		else
		begin
			// Ready is offered only while the slot is empty, so one write at a time
			s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !wHeld && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld <= 1'b1;
				wByte <= s_axi_wdata[7:0];
				wLane0 <= s_axi_wstrb[0];
			end
			if (writeNow)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= isMapped(writeIdx) ? ASC_RESP_OKAY : ASC_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				awHeld <= 1'b0;
				wHeld <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel

	assign readNow = s_axi_arvalid && s_axi_arready;
	assign readIdx = regIndex(s_axi_araddr);

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= ASC_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !readNow;
			if (readNow)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= isMapped(readIdx) ? ASC_RESP_OKAY : ASC_RESP_SLVERR;
				case (readIdx)
					ASC_IDX_RESULT: s_axi_rdata <= {24'h000000, conversionResult};
					ASC_IDX_CTRL_MAIN: s_axi_rdata <= {24'h000000, clockSelect, channelLow,
						goDone, internalSource, powerOn};
					ASC_IDX_REF_SEL: s_axi_rdata <= {24'h000000, 2'h0, referenceSelect,
						4'h0};
					// Analog pins read zero so a digital reader never sees a floating level
					ASC_IDX_PORT_A: s_axi_rdata <= {24'h000000, portAPins[7:4],
						portAPins[3:0] & ~analogSelect[3:0]};
					ASC_IDX_PORT_B: s_axi_rdata <= {24'h000000, portBPins[7:4],
						portBPins[3:0] & ~analogSelect[7:4]};
					ASC_IDX_IRQ: s_axi_rdata <= {30'h00000000, irqEnable, completeFlag};
					ASC_IDX_ANALOG_SEL: s_axi_rdata <= {24'h000000, analogSelect};
					default: s_axi_rdata <= 32'h0000_0000;
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control register 0

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			powerOn <= ASC_CTRL_RESET[ASC_POWER_BIT];
			internalSource <= ASC_CTRL_RESET[ASC_INT_SRC_BIT];
			goDone <= ASC_CTRL_RESET[ASC_GO_BIT];
			channelLow <= ASC_CTRL_RESET[ASC_CHAN_LSB +: 3];
			clockSelect <= ASC_CTRL_RESET[ASC_CLKSEL_LSB +: 2];
		end
		else
		begin
			if (writeNow && wLane0 && writeIdx == ASC_IDX_CTRL_MAIN)
			begin
				powerOn <= wByte[ASC_POWER_BIT];
				internalSource <= wByte[ASC_INT_SRC_BIT];
				channelLow <= wByte[ASC_CHAN_LSB +: 3];
				clockSelect <= wByte[ASC_CLKSEL_LSB +: 2];
				goDone <= wByte[ASC_GO_BIT] && wByte[ASC_POWER_BIT];
			end
			// Completion beats a simultaneous software write of the go bit
			if (sarDone)
				goDone <= 1'b0;
			else if (!powerOn)
				goDone <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control register 1, result, interrupt and analog select registers

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			referenceSelect <= ASC_CTRL_RESET[ASC_REFSEL_LSB +: 2];
		else if (writeNow && wLane0 && writeIdx == ASC_IDX_REF_SEL)
			referenceSelect <= wByte[ASC_REFSEL_LSB +: 2];
	end

	// No reset: the result is undefined until the first load
	always_ff @(posedge core_clk)
	begin
		if (sarDone)
			conversionResult <= sarTrial;
		else if (writeNow && wLane0 && writeIdx == ASC_IDX_RESULT)
			conversionResult <= wByte;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			completeFlag <= 1'b0;
			irqEnable <= 1'b0;
			irqRequest <= 1'b0;
		end
		else
		begin
			if (writeNow && wLane0 && writeIdx == ASC_IDX_IRQ)
			begin
				completeFlag <= wByte[ASC_FLAG_BIT];
				irqEnable <= wByte[ASC_IRQEN_BIT];
			end
			// Set wins over a clear in the same cycle
			if (sarDone)
				completeFlag <= 1'b1;
			irqRequest <= completeFlag && irqEnable;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			analogSelect <= 8'h00;
		else if (writeNow && wLane0 && writeIdx == ASC_IDX_ANALOG_SEL)
			analogSelect <= wByte;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Conversion sequencing

	assign sarStart = (state == ASC_ACQUIRE) && powerOn && goDone;
	assign sarAbort = (state == ASC_CONVERT) && (!goDone || !powerOn);

	always_ff @(posedge core_clk)
	begin
		if (sys_rst || !powerOn)
		begin
			state <= ASC_ACQUIRE;
			abortHalves <= 5'h00;
		end
		else
		begin
			case (state)
				ASC_ACQUIRE:
					if (sarStart)
						state <= ASC_CONVERT;
				ASC_CONVERT:
				begin
					if (sarAbort)
					begin
						state <= ASC_ABORT_WAIT;
						abortHalves <= 5'h00;
					end
					else if (sarDone)
						state <= ASC_ACQUIRE;
				end
				ASC_ABORT_WAIT:
				begin
					if (halfTick)
						abortHalves <= abortHalves + 5'h01;
					if (halfTick && abortHalves == ASC_ABORT_HALVES - 5'h01)
						state <= ASC_ACQUIRE;
				end
				default: state <= ASC_ACQUIRE;
			endcase
		end
	end

	asc_step_clock u_step_clock (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.run(powerOn && state != ASC_ACQUIRE),
		.clockSelect(clockSelect),
		.rcHalfTick(rcHalfTick),
		.cpuSleep(cpuSleep),
		.halfTick(halfTick)
	);

	asc_sar u_sar (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.start(sarStart),
		.abort(sarAbort),
		.halfTick(halfTick),
		.compareHigh(compareHigh),
		.busy(sarBusy),
		.sampling(sarSampling),
		.done(sarDone),
		.trial(sarTrial)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Analog side controls

	// Internal codes above 001 are reserved and leave the hold capacitor open
	assign channelValid = !internalSource || channelLow[2:1] == 2'h0;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			analog <= '0;
		else
		begin
			analog.powered <= powerOn;
			analog.connect <= powerOn && channelValid;
			analog.internalSource <= internalSource;
			analog.channel <= channelLow;
			analog.reference <= referenceSelect;
			// Track in acquisition and the opening halves, hold through the bit trials
			analog.sampling <= powerOn && channelValid &&
				((state == ASC_ACQUIRE) || (sarBusy && sarSampling));
			analog.trial <= sarTrial;
		end
	end

endmodule
`default_nettype wire

// ==== dv/asc_analog_model.sv ====
// Behavioural multiplexer, sample-hold and comparator facing the converter control.
// Assumes the trial value settles before the engine samples the comparator.
`timescale 1ns/100ps
`default_nettype none
module asc_analog_model
	import asc_pkg::*;
(
	input wire logic core_clk,
	input wire asc_analog_t analog,
	output logic compareHigh
);
	// Plain always so the start value is not a second driver
	logic [7:0] held = 8'h00;

	// Each source carries a level that encodes its own code, so a misroute shows
	// Nothing connected: the cap drifts, so the level flips at every sample
	always @(posedge core_clk)
	begin
		if (analog.sampling)
			held <= analog.connect ? {analog.internalSource, analog.channel, 4'h9} : ~held;
	end

	assign compareHigh = (held >= analog.trial);
endmodule
`default_nettype wire

// ==== dv/asc_control_assertions.sv ====
// Protocol and analog-control checks on the converter control top ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module asc_control_assertions
	import asc_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire asc_analog_t analog,
	input wire logic irqRequest
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	////////////////////////////////
	sequence wrTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence wrAnswer;
		(!s_axi_awready && !s_axi_wready) ##1 s_axi_bvalid;
	endsequence
	sequence rdTaken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	AST_WRITE_ANSWER:
		assert property (wrTaken |=> wrAnswer)
		else $error("write not answered in time");
	AST_READ_ANSWER:
		assert property (rdTaken |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0 && !s_axi_arready)
		else $error("read not answered next cycle");
	AST_R_HOLD:
		assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before handshake");
	AST_B_RELEASE:
		assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response held after handshake");
	AST_POWER_OFF:
		assert property (!analog.powered |-> !analog.connect && !analog.sampling)
		else $error("input connected while converter off");
	AST_EXT_ROUTE:
		assert property (analog.powered && !analog.internalSource |-> analog.connect)
		else $error("external channel not connected");
	AST_RESERVED:
		assert property (analog.powered && analog.internalSource && analog.channel > 3'h1
			|-> !analog.connect)
		else $error("reserved code connected an input");
	AST_RESET_STATE:
		assert property ($past(sys_rst) |-> !s_axi_bvalid && !s_axi_rvalid && !irqRequest
			&& !analog.powered)
		else $error("state not cleared by reset");
endmodule
bind asc_control asc_control_assertions asc_control_assertions_inst (.core_clk(core_clk),
	.sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.analog(analog), .irqRequest(irqRequest));
`default_nettype wire

// ==== dv/testbench.sv ====
// Register-level bench: conversions on every clock source and channel, abort, sleep.
// Assumes the analog model answers the comparator and a 5-cycle RC half period.
`timescale 1ns/100ps
`default_nettype none
module testbench
	import asc_pkg::*;
;
	localparam logic [11:0] resAddr = {ASC_IDX_RESULT, 2'h0};
	localparam logic [11:0] ctrlAddr = {ASC_IDX_CTRL_MAIN, 2'h0};
	localparam logic [11:0] refAddr = {ASC_IDX_REF_SEL, 2'h0};
	localparam logic [11:0] irqAddr = {ASC_IDX_IRQ, 2'h0};
	localparam logic [11:0] selAddr = {ASC_IDX_ANALOG_SEL, 2'h0};
	localparam logic [11:0] badAddr = 12'hffc;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cpuSleep = 1'b0, rcHalfTick = 1'b0;
	logic [7:0] portAPins = 8'hff, portBPins = 8'hff;
	logic [2:0] rcCount = 3'h0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic compareHigh, irqRequest;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire asc_analog_t analog;
	int failures = 0;
	int num_checks = 0;

	asc_control asc_control_inst (.core_clk(core_clk), .sys_rst(sys_rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cpuSleep(cpuSleep),
		.rcHalfTick(rcHalfTick), .compareHigh(compareHigh), .portAPins(portAPins),
		.portBPins(portBPins), .analog(analog), .irqRequest(irqRequest));
	asc_analog_model asc_analog_model_inst (.core_clk(core_clk), .analog(analog),
		.compareHigh(compareHigh));

	always #2 core_clk = ~core_clk;
	// Free-running RC oscillator, one pulse per half period
	always @(posedge core_clk)
	begin
		rcCount <= (rcCount == 3'h4) ? 3'h0 : rcCount + 3'h1;
		rcHalfTick <= (rcCount == 3'h4);
	end

	////////////////////////////////
	task automatic report_and_stop();
		$display("Counts: %0d checks, %0d mismatches", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic tick(inout int n);
		@(posedge core_clk);
		n++;
		if (n > 2000)
		begin
			failures++;
			$display("BAD wait expected answer seen none");
			report_and_stop();
		end
	endtask
	// Unmapped place answers with an error code, everything else OKAY
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		int n;
		logic pa;
		logic pw;
		n = 0;
		pa = 1'b1;
		pw = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (pa || pw)
		begin
			tick(n);
			if (pa && s_axi_awready)
			begin
				pa = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (pw && s_axi_wready)
			begin
				pw = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!s_axi_bvalid)
			tick(n);
		chk("bresp", {30'h0, s_axi_bresp}, {30'h0, a == badAddr ? ASC_RESP_SLVERR : ASC_RESP_OKAY});
		s_axi_bready <= 1'b0;
		tick(n);
	endtask
	// Ready waits high with the request; data is taken at the edge that shows valid
	task automatic rdc(input logic [11:0] a, input logic [31:0] want, input string what);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do tick(n); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid)
			tick(n);
		chk(what, s_axi_rdata, want);
		chk("rresp", {30'h0, s_axi_rresp}, {30'h0, a == badAddr ? ASC_RESP_SLVERR : ASC_RESP_OKAY});
		s_axi_rready <= 1'b0;
		tick(n);
	endtask
	task automatic conv(input logic [7:0] ctl, input int h, input logic [7:0] want, input logic res);
		int n;
		n = 0;
		wr(ctrlAddr, ctl & 8'hfb);
		wr(ctrlAddr, ctl | 8'h04);
		while (!irqRequest)
			tick(n);
		chk("convCycles", 32'(n >= 19 * h - 3 && n <= 19 * h + 9), 32'h1);
		rdc(ctrlAddr, {24'h0, ctl & 8'hfb}, "goCleared");
		if (res)
			rdc(resAddr, {24'h0, want}, "result");
		rdc(irqAddr, 32'h3, "flagSet");
		wr(irqAddr, 8'h02);
		chk("irqCleared", {31'h0, irqRequest}, 32'h0);
	endtask

	////////////////////////////////
	initial
	begin
		logic [7:0] ctl;
		int h;
		int n;
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		rdc(ctrlAddr, 32'h0, "ctrlMainReset");
		rdc(refAddr, 32'h0, "refReset");
		wr(refAddr, 8'hff);
		rdc(refAddr, 32'h30, "refUnused");
		wr(ctrlAddr, 8'h01);
		for (int r = 0; r < 4; r++)
		begin
			wr(refAddr, 8'(r << 4));
			chk("reference", {30'h0, analog.reference}, 32'(r));
		end
		$display("test registers done");
		wr(irqAddr, 8'h02);
		wr(selAddr, 8'hff);
		for (int i = 0; i < 11; i++)
		begin
			h = (i % 4 == 3) ? 5 : (i % 4 == 2 ? 16 : (i % 4 == 1 ? 4 : 1));
			cpuSleep <= (i % 4 == 3);
			ctl = {2'(i % 4), 3'(i == 10 ? 3 : i % 8), 1'b0, 1'(i > 7), 1'b1};
			conv(ctl, h, {ctl[1], ctl[5:3], 4'h9}, i < 10);
		end
		cpuSleep <= 1'b0;
		$display("test conversions done");
		wr(resAddr, 8'h5a);
		rdc(resAddr, 32'h5a, "resultWrite");
		wr(ctrlAddr, 8'h89);
		wr(ctrlAddr, 8'h8d);
		repeat (40) @(posedge core_clk);
		wr(ctrlAddr, 8'h89);
		repeat (100) @(posedge core_clk);
		rdc(resAddr, 32'h5a, "abortKeeps");
		rdc(irqAddr, 32'h2, "abortNoFlag");
		conv(8'h89, 16, 8'h19, 1'b1);
		wr(ctrlAddr, 8'h8d);
		repeat (40) @(posedge core_clk);
		wr(ctrlAddr, 8'h8c);
		chk("powered", {31'h0, analog.powered}, 32'h0);
		repeat (350) @(posedge core_clk);
		rdc(ctrlAddr, 32'h88, "powerOffGo");
		rdc(irqAddr, 32'h2, "powerOffNoFlag");
		$display("test abort done");
		cpuSleep <= 1'b1;
		wr(ctrlAddr, 8'h89);
		wr(ctrlAddr, 8'h8d);
		repeat (400) @(posedge core_clk);
		rdc(ctrlAddr, 32'h8d, "sleepFreezes");
		cpuSleep <= 1'b0;
		n = 0;
		while (!irqRequest)
			tick(n);
		rdc(resAddr, 32'h19, "afterWake");
		wr(irqAddr, 8'h01);
		chk("irqMasked", {31'h0, irqRequest}, 32'h0);
		wr(selAddr, 8'h35);
		rdc({ASC_IDX_PORT_A, 2'h0}, 32'hfa, "port_a_pins");
		rdc({ASC_IDX_PORT_B, 2'h0}, 32'hfc, "port_b_pins");
		wr(badAddr, 8'h01);
		rdc(badAddr, 32'h0, "unmapped");
		$display("test sleep and ports done");
		report_and_stop();
	end
endmodule
`default_nettype wire
